// ==== shared/cmac_regs.svh ====
`ifndef CMAC_REGS_SVH
`define CMAC_REGS_SVH

// ROM map: application region first, test region on top
`define CMAC_ROM_TEST_BASE 19'h42000
`define CMAC_ROM_SIZE 19'h48000

// EEPROM map: manufacturer area, contactless OS area, application
`define CMAC_EE_MFR_SIZE 19'h00080
`define CMAC_EE_CLOS_ZERO 19'h00000
`define CMAC_EE_CLOS_1K 19'h00400
`define CMAC_EE_CLOS_4K 19'h01000
`define CMAC_EE_SIZE 19'h24000

// RAM map: contactless OS area, general purpose, coprocessor RAM
`define CMAC_RAM_CLOS_ZERO 19'h00000
`define CMAC_RAM_CLOS_SIZE 19'h00080
`define CMAC_RAM_COP_BASE 19'h01400
`define CMAC_RAM_SIZE 19'h01E00

// Special function registers: upper half, top slice open to user mode
`define CMAC_SFR_BASE 19'h00080
`define CMAC_SFR_END 19'h00100
`define CMAC_SFR_USER_BASE 19'h000E0

// Fixed ROM vectors, eight bytes apart
`define CMAC_EXC_VEC_BASE 19'h00000
`define CMAC_IRQ_VEC_BASE 19'h00400
`define CMAC_CONFIG_CALL_VECTOR_BASE 19'h00100
`define CMAC_CONFIG_CALL_VECTOR_SPAN 19'h00040
`define CMAC_SYSTEM_CALL_VECTOR_BASE 19'h00200
`define CMAC_SYSTEM_CALL_VECTOR_SPAN 19'h00100
`define CMAC_VIOL_IDX 5'h1F

// Emulation strap codes
`define CMAC_STRAP_ONE_KBYTE 2'h1
`define CMAC_STRAP_FOUR_KBYTE 2'h2

`endif

// ==== shared/cmac_pkg.sv ====
`include "cmac_regs.svh"

package cmac_pkg;

    typedef enum logic [2:0] {
        cmac_boot,
        cmac_test,
        cmac_contactless_os_mode,
        cmac_system,
        cmac_user
    } cmac_mode_e;

    typedef enum logic [1:0] {
        space_rom,
        space_eeprom,
        space_ram,
        space_sfr
    } cmac_space_e;

    typedef enum logic [1:0] {
        emulation_zero,
        emulation_one_kbyte,
        emulation_four_kbyte
    } cmac_emul_e;

    typedef enum logic [3:0] {
        rgn_none,
        rgn_rom_app,
        rgn_rom_test,
        rgn_ee_mfr,
        rgn_ee_clos,
        rgn_ee_app,
        rgn_ram_clos,
        rgn_ram_gp,
        rgn_ram_cop,
        rgn_sfr_user,
        rgn_sfr_priv
    } cmac_region_e;

    typedef logic [18:0] cmac_addr_t;

    typedef struct packed {
        logic valid;
        logic fetch;
        logic write;
        cmac_space_e space;
        cmac_addr_t addr;
    } cmac_access_s;

    typedef struct packed {
        logic exc;
        logic irq;
        logic [4:0] idx;
    } cmac_event_s;

    typedef struct packed {
        logic valid;
        cmac_addr_t addr;
    } cmac_redirect_s;

    function automatic cmac_addr_t clos_ee_size(cmac_emul_e e);
        unique case (e)
            emulation_zero: clos_ee_size = `CMAC_EE_CLOS_ZERO;
            emulation_one_kbyte: clos_ee_size = `CMAC_EE_CLOS_1K;
            emulation_four_kbyte: clos_ee_size = `CMAC_EE_CLOS_4K;
            default: clos_ee_size = `CMAC_EE_CLOS_4K;
        endcase
    endfunction : clos_ee_size

    function automatic cmac_addr_t clos_ram_size(cmac_emul_e e);
        if (e == emulation_zero) begin
            clos_ram_size = `CMAC_RAM_CLOS_ZERO;
        end else begin
            clos_ram_size = `CMAC_RAM_CLOS_SIZE;
        end
    endfunction : clos_ram_size

endpackage : cmac_pkg

// ==== design/cmac_sync.sv ====
`timescale 1ns/10ps

module cmac_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    import cmac_pkg::*;

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule : cmac_sync

// ==== design/cmac_region_decode.sv ====
`timescale 1ns/10ps
`include "cmac_regs.svh"

module cmac_region_decode (
    input cmac_pkg::cmac_access_s acc,
    input cmac_pkg::cmac_emul_e emul,
    output cmac_pkg::cmac_region_e region
);
    import cmac_pkg::*;

    cmac_addr_t ee_clos_end;

    always_comb begin
        ee_clos_end = `CMAC_EE_MFR_SIZE + clos_ee_size(emul);
        region = rgn_none;
        unique case (acc.space)
            space_rom: begin
                if (acc.addr < `CMAC_ROM_TEST_BASE) begin
                    region = rgn_rom_app;
                end else if (acc.addr < `CMAC_ROM_SIZE) begin
                    region = rgn_rom_test;
                end
            end
            space_eeprom: begin
                if (acc.addr < `CMAC_EE_MFR_SIZE) begin
                    region = rgn_ee_mfr;
                end else if (acc.addr < ee_clos_end) begin
                    region = rgn_ee_clos;
                end else if (acc.addr < `CMAC_EE_SIZE) begin
                    region = rgn_ee_app;
                end
            end
            space_ram: begin
                if (acc.addr < clos_ram_size(emul)) begin
                    region = rgn_ram_clos;
                end else if (acc.addr < `CMAC_RAM_COP_BASE) begin
                    region = rgn_ram_gp;
                end else if (acc.addr < `CMAC_RAM_SIZE) begin
                    region = rgn_ram_cop;
                end
            end
            space_sfr: begin
                if (acc.addr >= `CMAC_SFR_USER_BASE &&
                    acc.addr < `CMAC_SFR_END) begin
                    region = rgn_sfr_user;
                end else if (acc.addr >= `CMAC_SFR_BASE &&
                             acc.addr < `CMAC_SFR_USER_BASE) begin
                    region = rgn_sfr_priv;
                end
            end
        endcase
    end

endmodule : cmac_region_decode

// ==== design/cmac_mode_ctrl.sv ====
// Operation
// R1: Five CPU modes; boot, test, contactless OS held in a hidden register.
// R2: Before test lockout, every reset finishes in test mode.
// R3: After test lockout, every reset finishes in system mode.
// R4: Test mode is locked out permanently by hardware after production.
// R5: Every reset starts in boot mode, running the boot firmware.
// R6: System mode reaches everything; user mode only granted SFRs. Code gives system mode only application memory and SFRs.
// R7: Exceptions and interrupts jump to fixed vectors, set vector's mode. Code ignores them in boot and test modes.
// R8: Jump to one of eight config vectors enters contactless OS mode.
// R9: Jump to one of 32 system call vectors enters system mode.
// R10: ROM splits into 264 kB application and 24 kB test region.
// R11: EEPROM keeps 128 B for maker plus 0, 1 or 4 kB.
// R12: RAM gives OS 0 B under C, else 128 B of 7680.
// R13: Test mode may access every memory region.
// R14: Boot and OS modes reach only test ROM and OS areas. Code also grants them maker EEPROM and SFRs.
// R15: Application memory only in system/user; user further gated by MMU.
// R16: Coprocessor reaches only its 2560 B RAM; CPU reaches both parts. Code also grants the coprocessor application EEPROM.
// R17: Coprocessor RAM and EEPROM accesses bypass the MMU check.
// R18: Forbidden CPU access is blocked and raises a system-mode exception. Code raises no exception in test mode.
`timescale 1ns/10ps
`include "cmac_regs.svh"

module cmac_mode_ctrl #(
    parameter logic [31:0] EXC_USER_MASK = 32'h00000000,
    parameter logic [31:0] IRQ_USER_MASK = 32'h00000000
) (
    input wire logic clock,
    input wire logic reset_n,
    input cmac_pkg::cmac_access_s cpu_acc,
    input wire logic cpu_mmu_allow,
    input wire logic sfr_user_grant,
    output logic cpu_grant,
    input wire logic mmu_cfg_wr,
    output logic mmu_cfg_wr_en,
    input cmac_pkg::cmac_access_s copro_acc,
    output logic copro_grant,
    input cmac_pkg::cmac_event_s event_in,
    input wire logic boot_done,
    input wire logic fuse_blown,
    input wire logic fuse_burn_req,
    output logic fuse_burn,
    input wire logic [1:0] emul_strap,
    output cmac_pkg::cmac_mode_e mode,
    output logic super_mode,
    output logic test_locked,
    output cmac_pkg::cmac_redirect_s redirect,
    output logic violation
);
    import cmac_pkg::*;

    cmac_mode_e mode_r;
    cmac_mode_e mode_nxt;
    cmac_emul_e emul_r;
    cmac_redirect_s redirect_r;
    cmac_redirect_s redirect_nxt;
    cmac_region_e cpu_region;
    cmac_region_e copro_region;
    logic test_lock_r;
    logic fuse_burn_r;
    logic violation_r;
    logic fuse_sync;
    logic [1:0] strap_sync;
    logic take_viol;
    logic take_exc;
    logic take_irq;
    logic take_config_call_vector;
    logic take_system_call_vector;
    logic vec_fetch;

    function automatic logic in_table(cmac_addr_t a, cmac_addr_t base,
                                      cmac_addr_t span);
        in_table = (a >= base) && (a < base + span);
    endfunction : in_table

    function automatic logic is_app_mem(cmac_region_e r);
        is_app_mem = (r == rgn_rom_app) || (r == rgn_ee_app) ||
                     (r == rgn_ram_gp) || (r == rgn_ram_cop);
    endfunction : is_app_mem

    function automatic logic allowed(cmac_mode_e m, cmac_region_e r,
                                     logic mmu_ok, logic sfr_ok);
        unique case (m)
            cmac_test: allowed = (r != rgn_none); // see R13
            cmac_boot, cmac_contactless_os_mode: begin
                // Firmware modes stay out of application memory
                allowed = (r == rgn_rom_test) || (r == rgn_ee_mfr) ||
                          (r == rgn_ee_clos) || (r == rgn_ram_clos) ||
                          (r == rgn_sfr_user) ||
                          (r == rgn_sfr_priv); // see R14
            end
            cmac_system: begin
                allowed = is_app_mem(r) || (r == rgn_sfr_user) ||
                          (r == rgn_sfr_priv); // see R6
            end
            cmac_user: begin
                allowed = (is_app_mem(r) && mmu_ok) || // see R15
                          (r == rgn_sfr_user) ||
                          (r == rgn_sfr_priv && sfr_ok); // see R6
            end
            // Illegal mode codes grant nothing
            default: allowed = 1'b0;
        endcase
    endfunction : allowed

    cmac_sync #(.WIDTH(3)) u_pin_sync (
        .clock(clock),
        .reset_n(reset_n),
        .din({fuse_blown, emul_strap}),
        .dout({fuse_sync, strap_sync})
    );

    // Two decoders: CPU path and coprocessor path see the same map
    cmac_region_decode u_cpu_decode ( // see R10
        .acc(cpu_acc),
        .emul(emul_r),
        .region(cpu_region)
    );

    cmac_region_decode u_copro_decode (
        .acc(copro_acc),
        .emul(emul_r),
        .region(copro_region)
    );

    // Strap is taken while the boot firmware runs, then frozen
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            emul_r <= emulation_zero;
        end else if (mode_r == cmac_boot) begin
            unique case (strap_sync) // see R11 see R12
                `CMAC_STRAP_ONE_KBYTE: emul_r <= emulation_one_kbyte;
                `CMAC_STRAP_FOUR_KBYTE: emul_r <= emulation_four_kbyte;
                2'h0: emul_r <= emulation_zero;
                default: emul_r <= emulation_four_kbyte;
            endcase
        end
    end

    // Lockout follows the fuse; only test firmware may burn it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            test_lock_r <= 1'b0;
        end else if (fuse_sync ||
                     (mode_r == cmac_test && fuse_burn_req)) begin
            test_lock_r <= 1'b1; // see R4
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fuse_burn_r <= 1'b0;
        end else begin
            fuse_burn_r <= (mode_r == cmac_test) && fuse_burn_req &&
                           !test_lock_r; // see R4
        end
    end

    assign cpu_grant = cpu_acc.valid &&
                       allowed(mode_r, cpu_region, cpu_mmu_allow,
                               sfr_user_grant);

    // No MMU term here: the coprocessor path is not checked by it
    assign copro_grant = copro_acc.valid &&
                         (copro_region == rgn_ram_cop ||
                          copro_region == rgn_ee_app); // see R16 see R17

    assign mmu_cfg_wr_en = mmu_cfg_wr && (mode_r == cmac_system); // see R15

    // Test mode never violates; anything unmapped there is just ignored
    assign take_viol = cpu_acc.valid && !cpu_grant &&
                       mode_r != cmac_test; // see R18
    assign take_exc = event_in.exc && mode_r != cmac_boot &&
                      mode_r != cmac_test;
    assign take_irq = event_in.irq && mode_r != cmac_boot &&
                      mode_r != cmac_test;
    assign vec_fetch = cpu_grant && cpu_acc.fetch &&
                       cpu_acc.space == space_rom;
    assign take_config_call_vector = vec_fetch &&
                       in_table(cpu_acc.addr, `CMAC_CONFIG_CALL_VECTOR_BASE,
                                `CMAC_CONFIG_CALL_VECTOR_SPAN); // see R8
    assign take_system_call_vector = vec_fetch &&
                       in_table(cpu_acc.addr, `CMAC_SYSTEM_CALL_VECTOR_BASE,
                                `CMAC_SYSTEM_CALL_VECTOR_SPAN); // see R9

    always_comb begin
        mode_nxt = mode_r;
        redirect_nxt = '0;
        if (take_viol) begin
            mode_nxt = cmac_system; // see R18
            redirect_nxt.valid = 1'b1;
            redirect_nxt.addr = `CMAC_EXC_VEC_BASE +
                                {11'h000, `CMAC_VIOL_IDX, 3'h0};
        end else if (take_exc) begin
            mode_nxt = EXC_USER_MASK[event_in.idx] ? cmac_user :
                       cmac_system; // see R7
            redirect_nxt.valid = 1'b1;
            redirect_nxt.addr = `CMAC_EXC_VEC_BASE +
                                {11'h000, event_in.idx, 3'h0};
        end else if (take_irq) begin
            mode_nxt = IRQ_USER_MASK[event_in.idx] ? cmac_user :
                       cmac_system; // see R7
            redirect_nxt.valid = 1'b1;
            redirect_nxt.addr = `CMAC_IRQ_VEC_BASE +
                                {11'h000, event_in.idx, 3'h0};
        end else if (take_config_call_vector) begin
            mode_nxt = cmac_contactless_os_mode; // see R8
        end else if (take_system_call_vector) begin
            mode_nxt = cmac_system; // see R9
        end else if (mode_r == cmac_boot && boot_done) begin
            mode_nxt = test_lock_r ? cmac_system :
                       cmac_test; // see R2 see R3
        end
    end

    // Mode lives only here; no software write path reaches it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mode_r <= cmac_boot; // see R5 see R1
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            redirect_r <= '0;
            violation_r <= 1'b0;
        end else begin
            redirect_r <= redirect_nxt;
            violation_r <= take_viol; // see R18
        end
    end

    assign mode = mode_r;
    assign super_mode = (mode_r == cmac_boot) || (mode_r == cmac_test) ||
                        (mode_r == cmac_contactless_os_mode); // see R1
    assign test_locked = test_lock_r;
    assign redirect = redirect_r;
    assign violation = violation_r;
    assign fuse_burn = fuse_burn_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    property reset_to_boot_p;
        @(posedge clock) $rose(reset_n) |-> mode_r == cmac_boot;
    endproperty

    boot_after_reset_a: assert property (reset_to_boot_p) // see R5
        else $error("reset did not start in boot mode");

    test_entry_a: assert property ( // see R2
        mode_r == cmac_boot && boot_done && !test_lock_r && !take_viol
        |=> mode_r == cmac_test)
        else $error("boot end without lockout missed test mode");

    system_entry_a: assert property ( // see R3
        mode_r == cmac_boot && boot_done && test_lock_r
        |=> mode_r == cmac_system)
        else $error("boot end after lockout missed system mode");

    lock_sticky_a: assert property ( // see R4
        test_lock_r && mode_r != cmac_test
        |=> test_lock_r && mode_r != cmac_test)
        else $error("test lockout released or test mode re-entered");

    exc_vector_a: assert property ( // see R7
        take_exc && !take_viol
        |=> redirect.valid && mode_r inside {cmac_system, cmac_user} &&
            redirect.addr == `CMAC_EXC_VEC_BASE +
                             {11'h000, $past(event_in.idx), 3'h0})
        else $error("exception did not vector with its mode");

    config_call_vector_mode_a: assert property ( // see R8
        take_config_call_vector && !take_viol && !take_exc && !take_irq
        |=> mode_r == cmac_contactless_os_mode)
        else $error("config vector did not enter contactless OS mode");

    system_call_vector_mode_a: assert property ( // see R9
        take_system_call_vector && !take_exc && !take_irq |=> mode_r == cmac_system)
        else $error("system call vector did not enter system mode");

    test_open_a: assert property ( // see R13
        mode_r == cmac_test && cpu_acc.valid && cpu_region != rgn_none
        |-> cpu_grant)
        else $error("test mode access refused");

    firmware_fence_a: assert property ( // see R14
        mode_r inside {cmac_boot, cmac_contactless_os_mode} &&
        is_app_mem(cpu_region) |-> !cpu_grant)
        else $error("firmware mode reached application memory");

    user_mmu_a: assert property ( // see R15
        mode_r == cmac_user && cpu_grant && is_app_mem(cpu_region)
        |-> cpu_mmu_allow)
        else $error("user access passed without MMU approval");

    copro_window_a: assert property ( // see R16
        copro_grant |-> (copro_acc.space == space_ram &&
            copro_acc.addr >= `CMAC_RAM_COP_BASE &&
            copro_acc.addr < `CMAC_RAM_SIZE) ||
            (copro_acc.space == space_eeprom &&
             copro_acc.addr >= `CMAC_EE_MFR_SIZE + clos_ee_size(emul_r) &&
             copro_acc.addr < `CMAC_EE_SIZE))
        else $error("coprocessor left its window");

    viol_exc_a: assert property ( // see R18
        cpu_acc.valid && !cpu_grant && mode_r != cmac_test ##1 !take_viol
        |-> violation && redirect.valid && mode_r == cmac_system &&
            redirect.addr == `CMAC_EXC_VEC_BASE +
                             {11'h000, `CMAC_VIOL_IDX, 3'h0}
        ##1 !violation)
        else $error("blocked access did not raise one exception");

    boot_to_test_c: cover property (
        mode_r == cmac_boot ##1 mode_r == cmac_test);
    boot_to_system_c: cover property (
        mode_r == cmac_boot ##1 mode_r == cmac_system);
    config_call_vector_entry_c: cover property (
        mode_r == cmac_user ##[1:20] mode_r == cmac_contactless_os_mode);
    violation_c: cover property (
        mode_r == cmac_user && take_viol);

endmodule : cmac_mode_ctrl

// ==== bench/cmac_cpu_model.sv ====
`timescale 1ns/10ps

module cmac_cpu_model (
    input wire logic clock,
    output cmac_pkg::cmac_access_s cpu_acc,
    output cmac_pkg::cmac_access_s copro_acc,
    output cmac_pkg::cmac_event_s event_in
);
    import cmac_pkg::*;

    initial begin
        cpu_acc = '0;
        copro_acc = '0;
        event_in = '0;
    end

    // New request only after a falling edge, held for one full cycle
    task automatic issue(cmac_access_s a, cmac_access_s c, cmac_event_s e);
        @(negedge clock);
        cpu_acc = a;
        copro_acc = c;
        event_in = e;
    endtask : issue

    // Idle bus shows a toggling address so stale values never look valid
    task automatic release_bus();
        @(negedge clock);
        cpu_acc.valid = 1'h0;
        cpu_acc.addr = ~cpu_acc.addr;
        copro_acc.valid = 1'h0;
        copro_acc.addr = ~copro_acc.addr;
        event_in = '0;
    endtask : release_bus
endmodule : cmac_cpu_model

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps

module tb_top;
    import cmac_pkg::*;

    typedef struct packed {
        logic grant;
        logic cgrant;
        logic wr_en;
        logic fb;
        logic tl;
        logic viol;
        logic rv;
        cmac_mode_e mode;
        cmac_addr_t ra;
    } cmac_exp_s;

    logic clock = 1'h0;
    logic reset_n = 1'h0;
    logic cpu_mmu_allow = 1'h0;
    logic sfr_user_grant = 1'h0;
    logic mmu_cfg_wr = 1'h0;
    logic boot_done = 1'h0;
    logic fuse_blown = 1'h0;
    logic fuse_burn_req = 1'h0;
    logic [1:0] emul_strap = 2'h0;
    cmac_access_s cpu_acc;
    cmac_access_s copro_acc;
    cmac_event_s event_in;
    logic cpu_grant;
    logic mmu_cfg_wr_en;
    logic copro_grant;
    logic fuse_burn;
    cmac_mode_e mode;
    logic super_mode;
    logic test_locked;
    cmac_redirect_s redirect;
    logic violation;

    cmac_exp_s exp_q[$];
    cmac_mode_e cur = cmac_boot;
    logic lock = 1'h0;
    logic bd_v = 1'h0;
    logic fr_v = 1'h0;
    logic ma_v = 1'h0;
    logic sg_v = 1'h0;
    int err_count = 0;
    int compares = 0;
    int cyc_count = 0;
    localparam cmac_access_s no_acc = '0;
    localparam cmac_event_s no_ev = '0;

    always #5 clock = ~clock;

    cmac_cpu_model cpu_u (
        .clock(clock),
        .cpu_acc(cpu_acc),
        .copro_acc(copro_acc),
        .event_in(event_in)
    );

    // Exception vector 1 enters user mode, every other one system mode
    cmac_mode_ctrl #(
        .EXC_USER_MASK(32'h00000002),
        .IRQ_USER_MASK(32'h00000000)
    ) dut_u (
        .clock(clock), .reset_n(reset_n), .cpu_acc(cpu_acc),
        .cpu_mmu_allow(cpu_mmu_allow), .sfr_user_grant(sfr_user_grant),
        .cpu_grant(cpu_grant), .mmu_cfg_wr(mmu_cfg_wr),
        .mmu_cfg_wr_en(mmu_cfg_wr_en), .copro_acc(copro_acc),
        .copro_grant(copro_grant), .event_in(event_in),
        .boot_done(boot_done), .fuse_blown(fuse_blown),
        .fuse_burn_req(fuse_burn_req), .fuse_burn(fuse_burn),
        .emul_strap(emul_strap), .mode(mode), .super_mode(super_mode),
        .test_locked(test_locked), .redirect(redirect),
        .violation(violation)
    );

    task automatic tally_and_finish();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(string n, logic [18:0] e, logic [18:0] s);
        compares++;
        if (e !== s) begin
            err_count++;
            $display("FAIL %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk

    function automatic cmac_access_s ac(logic f, cmac_space_e sp,
            cmac_addr_t ad);
        ac = '{valid: 1'h1, fetch: f, write: 1'h0, space: sp, addr: ad};
    endfunction : ac

    // Expected outcome is worked out here and queued for the monitor
    task automatic step(cmac_access_s a, cmac_access_s c, cmac_event_s e,
            logic eg, logic ecg, cmac_mode_e nm);
        cmac_exp_s x;
        logic act;
        cpu_u.issue(a, c, e);
        boot_done = bd_v;
        fuse_burn_req = fr_v;
        cpu_mmu_allow = ma_v;
        sfr_user_grant = sg_v;
        mmu_cfg_wr = 1'($urandom_range(1, 0));
        act = !(cur inside {cmac_boot, cmac_test});
        x.grant = eg;
        x.cgrant = ecg;
        x.wr_en = mmu_cfg_wr && cur == cmac_system;
        x.viol = a.valid && !eg && cur != cmac_test;
        x.fb = fr_v && cur == cmac_test && !lock;
        lock = lock | x.fb;
        x.tl = lock;
        x.rv = x.viol || (act && (e.exc || e.irq));
        x.ra = (e.exc ? 19'h00000 : 19'h00400) + 19'({e.idx, 3'h0});
        if (x.viol) begin
            x.ra = 19'h000F8;
        end
        x.mode = x.viol ? cmac_system : nm;
        cur = x.mode;
        bd_v = 1'h0;
        fr_v = 1'h0;
        exp_q.push_back(x);
    endtask : step

    task automatic rd(cmac_space_e sp, cmac_addr_t ad, logic g);
        step(ac(1'h0, sp, ad), no_acc, no_ev, g, 1'h0, cur);
    endtask : rd

    task automatic cop(cmac_space_e sp, cmac_addr_t ad, logic g);
        step(no_acc, ac(1'h0, sp, ad), no_ev, 1'h0, g, cur);
    endtask : cop

    task automatic ex(logic x, logic i, logic [4:0] idx, cmac_mode_e nm);
        step(no_acc, no_acc, '{exc: x, irq: i, idx: idx}, 1'h0, 1'h0, nm);
    endtask : ex

    task automatic fe(cmac_addr_t ad, cmac_mode_e nm);
        step(ac(1'h1, space_rom, ad), no_acc, no_ev, 1'h1, 1'h0, nm);
    endtask : fe

    task automatic idle(int n);
        repeat (n) begin
            cpu_u.release_bus();
            boot_done = 1'h0;
            fuse_burn_req = 1'h0;
        end
    endtask : idle

    task automatic do_reset(logic f, logic [1:0] s);
        idle(1);
        reset_n = 1'h0;
        fuse_blown = f;
        emul_strap = s;
        repeat (12) @(negedge clock);
        reset_n = 1'h1;
        cur = cmac_boot;
        lock = f;
        // Strap and fuse need two edges to pass the synchronisers
        idle(4);
        step(ac(1'h0, space_rom, 19'h42000), no_acc, '{1'h1, 1'h0, 5'h03},
            1'h1, 1'h0, cmac_boot);
        bd_v = 1'h1;
        ex(1'h0, 1'h0, 5'h00, f ? cmac_system : cmac_test);
    endtask : do_reset

    always @(posedge clock) begin : monitor
        cmac_exp_s x;
        logic g;
        logic cg;
        logic we;
        if (exp_q.size() > 0) begin
            x = exp_q.pop_front();
            g = cpu_grant;
            cg = copro_grant;
            we = mmu_cfg_wr_en;
            #1;
            chk("cpu_grant", x.grant, g);
            chk("copro_grant", x.cgrant, cg);
            chk("mmu_cfg_wr_en", x.wr_en, we);
            chk("mode", 19'(x.mode), 19'(mode));
            chk("super_mode", x.mode inside {cmac_boot, cmac_test,
                cmac_contactless_os_mode}, super_mode);
            chk("violation", x.viol, violation);
            chk("fuse_burn", x.fb, fuse_burn);
            chk("test_locked", x.tl, test_locked);
            chk("redirect_valid", x.rv, redirect.valid);
            if (x.rv) begin
                chk("redirect_addr", x.ra, redirect.addr);
            end
        end
    end

    always @(posedge clock) begin
        cyc_count++;
        if (cyc_count == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(64756));
        do_reset(1'h0, 2'h0);
        rd(space_ram, 19'h01DFF, 1'h1);
        rd(space_rom, 19'h00010, 1'h1);
        rd(space_eeprom, 19'h23FFF, 1'h1);
        fr_v = 1'h1;
        ex(1'h1, 1'h0, 5'h02, cmac_test);
        fr_v = 1'h1;
        ex(1'h0, 1'h1, 5'h02, cmac_test);
        $display("test lockout done");
        do_reset(1'h1, 2'h2);
        rd(space_rom, 19'h41FFF, 1'h1);
        rd(space_rom, 19'h42000, 1'h0);
        rd(space_eeprom, 19'h0007F, 1'h0);
        rd(space_eeprom, 19'h0107F, 1'h0);
        rd(space_eeprom, 19'h01080, 1'h1);
        rd(space_ram, 19'h0007F, 1'h0);
        rd(space_ram, 19'h00080, 1'h1);
        rd(space_sfr, 19'h00080, 1'h1);
        cop(space_ram, 19'h01400, 1'h1);
        cop(space_ram, 19'h013FF, 1'h0);
        cop(space_eeprom, 19'h01080, 1'h1);
        for (int k = 0; k < 8; k++) begin
            fe(19'h00100 + 19'(k * 8), cmac_contactless_os_mode);
            rd(space_eeprom, 19'h00080 + 19'(k), 1'h1);
            rd(space_eeprom, 19'h0007F, 1'h1);
            rd(space_ram, 19'h01000, 1'h0);
        end
        ma_v = 1'h1;
        ex(1'h1, 1'h0, 5'h01, cmac_user);
        for (int k = 0; k < 32; k++) begin
            fe(19'h00200 + 19'(k * 8), cmac_system);
            ex(1'h1, 1'h0, 5'h01, cmac_user);
        end
        fe(19'h00138, cmac_contactless_os_mode);
        ex(1'h1, 1'h0, 5'h01, cmac_user);
        ma_v = 1'h0;
        rd(space_ram, 19'h01000, 1'h0);
        ex(1'h1, 1'h0, 5'h01, cmac_user);
        rd(space_sfr, 19'h000E0, 1'h1);
        rd(space_sfr, 19'h00080, 1'h0);
        ex(1'h1, 1'h0, 5'h01, cmac_user);
        sg_v = 1'h1;
        rd(space_sfr, 19'h00080, 1'h1);
        cop(space_eeprom, 19'h01080, 1'h1);
        rd(space_rom, 19'h42000, 1'h0);
        ex(1'h1, 1'h0, 5'h01, cmac_user);
        ex(1'h0, 1'h1, 5'h03, cmac_system);
        repeat (16) begin
            ex(1'h1, 1'h0, 5'($urandom_range(30, 2)), cmac_system);
            rd(space_ram, 19'($urandom_range(19'h01DFF, 19'h00080)),
                1'h1);
        end
        $display("test four kbyte emulation done");
        do_reset(1'h1, 2'h0);
        rd(space_ram, 19'h00000, 1'h1);
        rd(space_eeprom, 19'h00080, 1'h1);
        rd(space_eeprom, 19'h0007F, 1'h0);
        $display("test zero emulation done");
        do_reset(1'h1, 2'h1);
        rd(space_eeprom, 19'h0047F, 1'h0);
        rd(space_eeprom, 19'h00480, 1'h1);
        rd(space_ram, 19'h0007F, 1'h0);
        rd(space_ram, 19'h00080, 1'h1);
        $display("test one kbyte emulation done");
        do_reset(1'h1, 2'h3);
        fr_v = 1'h1;
        rd(space_eeprom, 19'h0107F, 1'h0);
        rd(space_eeprom, 19'h01080, 1'h1);
        $display("test spare strap code done");
        idle(3);
        tally_and_finish();
    end
endmodule : tb_top
